/* File: dpc_pkg.sv */
// Package for the dual-port memory port controller (host side).
// Assumes a 10 MHz core clock; all pin timing counted in core cycles.
package dpc_pkg;
  // Core clock period in ns
  localparam int CLK_NS          = 100;
  // Data and address widths of one memory port
  localparam int DATA_W          = 16;
  localparam int ADDR_W          = 13;
  // Least write pulse width, ns
  localparam int WRITE_PULSE_NS  = 25;
  // Least output turn-off plus data setup when output enable stays low, ns
  localparam int TURNOFF_SETUP_NS = 40;
  // Least write hold after collision flag release, ns
  localparam int WRITE_HOLD_NS   = 25;
  // Longest flag-release to valid data, ns
  localparam int FLAG_RELEASE_TO_DATA_NS = 45;
  // Cycle counts, times rounded up; read wait one cycle more
  localparam int WRITE_PULSE_CYC =
    (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRETCH_CYC =
    (TURNOFF_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_HOLD_CYC =
    (WRITE_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_WAIT_CYC =
    (FLAG_RELEASE_TO_DATA_NS + CLK_NS - 1) / CLK_NS + 1;
  // Counter width
  localparam int CNT_W = 4;
  // Request kinds
  typedef enum logic [1:0] {
    OP_ARRAY_WR = 2'b00,
    OP_ARRAY_RD = 2'b01,
    OP_SEM_WR   = 2'b10,
    OP_SEM_RD   = 2'b11
  } dpc_op_e;
endpackage

/* File: dpc_pins_if.sv */
// Interface bundling the pin-level strobes from sequencer to pin register.
// Assumes one clock domain; carries the unregistered values that the pin register then stores.
`timescale 1ns/100ps
interface dpc_pins_if;
  logic                        selN;     // Chip select, low active
  logic                        wrN;      // Write strobe, low active
  logic                        oeN;      // Output enable, low active
  logic                        upperN;   // Upper lane select, low active
  logic                        lowerN;   // Lower lane select, low active
  logic                        semN;     // Semaphore select, low active
  logic [dpc_pkg::ADDR_W-1:0]  addr;     // Address
  logic [dpc_pkg::DATA_W-1:0]  wdata;    // Write data
  logic                        dataOeN;  // Data pin enable, low drives
  modport src (output selN, wrN, oeN, upperN, lowerN, semN, addr, wdata,
               dataOeN);
  modport dst (input selN, wrN, oeN, upperN, lowerN, semN, addr, wdata,
               dataOeN);
endinterface

/* File: dpc_pin_reg.sv */
// Output register stage for all pin-level signals of one memory port.
// Assumes synchronous active-high reset; idles every strobe high.
`timescale 1ns/100ps
module dpc_pin_reg (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  dpc_pins_if.dst                         pin,
  output logic                            selN_r,
  output logic                            wrN_r,
  output logic                            oeN_r,
  output logic                            upperN_r,
  output logic                            lowerN_r,
  output logic                            semN_r,
  output logic [dpc_pkg::ADDR_W-1:0]      addr_r,
  output logic [dpc_pkg::DATA_W-1:0]      wdata_r,
  output logic                            dataOeN_r
);
  // Register every pin; reset leaves the port idle and undriven
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      selN_r    <= 1'b1;
      wrN_r     <= 1'b1;
      oeN_r     <= 1'b1;
      upperN_r  <= 1'b1;
      lowerN_r  <= 1'b1;
      semN_r    <= 1'b1;
      addr_r    <= '0;
      wdata_r   <= '0;
      dataOeN_r <= 1'b1;
    end else begin
      selN_r    <= pin.selN;
      wrN_r     <= pin.wrN;
      oeN_r     <= pin.oeN;
      upperN_r  <= pin.upperN;
      lowerN_r  <= pin.lowerN;
      semN_r    <= pin.semN;
      addr_r    <= pin.addr;
      wdata_r   <= pin.wdata;
      dataOeN_r <= pin.dataOeN;
    end
  end
endmodule

/* File: dpc_port_ctrl.sv */
// Host-side controller for one port of a dual-port static memory.
// Assumes pins are synchronous to core_clk; flag pin is a plain input.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Function
// - Address changes only while strobes are high
// - Array or semaphore select pin combinations
// - Write pulse of STRETCH_CYC when output enable low, 1 cycle like the normal pulse
// - Never drive data while device drives pins
// - Semaphore write-read keeps chip select high
// - Slave flag asserted before blocked write
// - Hold write strobe after flag release
module dpc_port_ctrl (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       reqValid,
  input  wire logic [1:0]                 reqOp,
  input  wire logic [dpc_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [dpc_pkg::DATA_W-1:0] reqData,
  input  wire logic [1:0]                 reqLanesN,
  input  wire logic                       keepOeLow,
  input  wire logic                       collisionN,
  input  wire logic [dpc_pkg::DATA_W-1:0] dataIn,
  output logic                            reqReady_r,
  output logic                            rspValid_r,
  output logic [dpc_pkg::DATA_W-1:0]      rspData_r,
  output logic                            selN_r,
  output logic                            wrN_r,
  output logic                            oeN_r,
  output logic                            upperN_r,
  output logic                            lowerN_r,
  output logic                            semN_r,
  output logic [dpc_pkg::ADDR_W-1:0]      addr_r,
  output logic [dpc_pkg::DATA_W-1:0]      dataOut_r,
  output logic                            dataOeN_r
);
  ////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,  // Waiting, all strobes high
    ST_SETUP = 3'b001,  // Address and selects applied, strobe high
    ST_PULSE = 3'b010,  // Write strobe low
    ST_HOLD  = 3'b011,  // Extra strobe time after flag release
    ST_READ  = 3'b100,  // Read access, waiting for data
    ST_DONE  = 3'b101   // Strobes released, answer given
  } dpc_state_e;

  dpc_state_e                     state_r, state_nxt;  // Sequencer
  logic [dpc_pkg::CNT_W-1:0]      cnt_r, cnt_nxt;      // Cycle counter
  logic [1:0]                     op_r;                // Latched kind
  logic [dpc_pkg::ADDR_W-1:0]     addrHold_r;          // Latched address
  logic [dpc_pkg::DATA_W-1:0]     dataHold_r;          // Latched data
  logic [1:0]                     lanes_r;             // Latched lanes
  logic                           oeLow_r;             // Latched oe mode
  logic                           wasBlocked_r;        // Flag seen low
  dpc_pins_if                     pin ();              // Pin bundle

  ////////////////////////////////////////////////////////////////////////
  // Decodes
  wire isSem    = op_r[1];
  wire isWrite  = ~op_r[0];
  wire blocked  = ~collisionN;
  wire active   = (state_r != ST_IDLE) && (state_r != ST_DONE);
  // Pulse length, STRETCH_CYC when output enable stays low; at 10 MHz both counts are 1 cycle
  wire [dpc_pkg::CNT_W-1:0] pulseCyc = oeLow_r ?
    dpc_pkg::CNT_W'(dpc_pkg::STRETCH_CYC) :
    dpc_pkg::CNT_W'(dpc_pkg::WRITE_PULSE_CYC);
  wire cntDone  = (cnt_r == '0);
  wire accepted = (state_r == ST_IDLE) && reqValid;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cntDone ? cnt_r : cnt_r - dpc_pkg::CNT_W'(1);
    case (state_r)
      ST_IDLE: begin
        if (reqValid) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (isWrite) begin
          // Strobe falls only after selects settle, one cycle later
          state_nxt = ST_PULSE;
          cnt_nxt   = pulseCyc - dpc_pkg::CNT_W'(1);
        end else begin
          state_nxt = ST_READ;
          cnt_nxt   = dpc_pkg::CNT_W'(dpc_pkg::READ_WAIT_CYC);
        end
      end
      ST_PULSE: begin
        if (blocked) begin
          // Device ignores the write; keep strobe low until release
          cnt_nxt = cnt_r;
        end else if (wasBlocked_r) begin
          state_nxt = ST_HOLD;
          cnt_nxt   = dpc_pkg::CNT_W'(dpc_pkg::WRITE_HOLD_CYC - 1);
        end else if (cntDone) begin
          state_nxt = ST_DONE;
        end
      end
      ST_HOLD: begin
        if (blocked) begin
          state_nxt = ST_PULSE;
        end else if (cntDone) begin
          state_nxt = ST_DONE;
        end
      end
      ST_READ: begin
        // Restart the data wait while the flag holds off valid data
        if (blocked) begin
          cnt_nxt = dpc_pkg::CNT_W'(dpc_pkg::READ_WAIT_CYC);
        end else if (cntDone) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin values; address and selects stay fixed while active
  // Array: chip select low, lanes as requested, semaphore high
  // Semaphore: chip select high and lanes high, semaphore low
  assign pin.selN    = ~(active && !isSem);
  assign pin.semN    = ~(active && isSem);
  assign pin.upperN  = (active && !isSem) ? lanes_r[1] : 1'b1;
  assign pin.lowerN  = (active && !isSem) ? lanes_r[0] : 1'b1;
  // Write strobe only after selects; with oeLow_r set the device drives in setup until it falls
  assign pin.wrN     = ~((state_r == ST_PULSE) || (state_r == ST_HOLD));
  assign pin.oeN     = ~((state_r == ST_READ) ||
                         (active && isWrite && oeLow_r));
  // Data driven only during the strobe, from the same cycle the strobe falls
  assign pin.dataOeN = ~((state_r == ST_PULSE) || (state_r == ST_HOLD));
  assign pin.addr    = addrHold_r;
  assign pin.wdata   = isSem ? {dpc_pkg::DATA_W{dataHold_r[0]}} :
                               dataHold_r;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and request registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r      <= ST_IDLE;
      cnt_r        <= '0;
      op_r         <= 2'b00;
      addrHold_r   <= '0;
      dataHold_r   <= '0;
      lanes_r      <= 2'b11;
      oeLow_r      <= 1'b0;
      wasBlocked_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (accepted) begin
        op_r         <= reqOp;
        addrHold_r   <= reqAddr;
        dataHold_r   <= reqData;
        lanes_r      <= reqLanesN;
        oeLow_r      <= keepOeLow;
        wasBlocked_r <= 1'b0;
      end else if (state_r == ST_PULSE) begin
        wasBlocked_r <= blocked;  // Remember a flag for the hold
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer side: ready, read data capture, one-cycle valid
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reqReady_r <= 1'b0;
      rspValid_r <= 1'b0;
      rspData_r  <= '0;
    end else begin
      reqReady_r <= (state_nxt == ST_IDLE);
      rspValid_r <= (state_r != ST_DONE) && (state_nxt == ST_DONE);
      if ((state_r == ST_READ) && !blocked && cntDone) begin
        // Semaphore reads return the same bit on every line
        rspData_r <= isSem ? {dpc_pkg::DATA_W{dataIn[0]}} : dataIn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin output registers
  dpc_pin_reg u_pins (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .pin       (pin),
    .selN_r    (selN_r),
    .wrN_r     (wrN_r),
    .oeN_r     (oeN_r),
    .upperN_r  (upperN_r),
    .lowerN_r  (lowerN_r),
    .semN_r    (semN_r),
    .addr_r    (addr_r),
    .wdata_r   (dataOut_r),
    .dataOeN_r (dataOeN_r)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks on driven pins
  property p_addr_stable;
    @(posedge core_clk) disable iff (sys_rst)
      (!wrN_r && $past(!wrN_r)) |-> $stable(addr_r);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("Address moved during write strobe");

  property p_select_excl;
    @(posedge core_clk) disable iff (sys_rst)
      !semN_r |-> (selN_r && upperN_r && lowerN_r);
  endproperty
  a_select_excl: assert property (p_select_excl)
    else $error("Semaphore access with array selects low");

  sequence s_strobe_fall;
    $fell(wrN_r);
  endsequence
  property p_select_first;
    @(posedge core_clk) disable iff (sys_rst)
      s_strobe_fall |-> $past(!selN_r || !semN_r);
  endproperty
  a_select_first: assert property (p_select_first)
    else $error("Write strobe fell before select");

  property p_no_contend;
    @(posedge core_clk) disable iff (sys_rst)
      !dataOeN_r |-> !wrN_r;
  endproperty
  a_no_contend: assert property (p_no_contend)
    else $error("Data driven outside write strobe");

  property p_hold_after_flag;
    @(posedge core_clk) disable iff (sys_rst)
      ($rose(collisionN) && !wrN_r) |=> !wrN_r;
  endproperty
  a_hold_after_flag: assert property (p_hold_after_flag)
    else $error("Write strobe released too soon after flag");

  property p_sem_rw;
    @(posedge core_clk) disable iff (sys_rst)
      !semN_r |-> selN_r;
  endproperty
  a_sem_rw: assert property (p_sem_rw)
    else $error("Chip select low during semaphore cycle");
endmodule

/* File: dpc_mem_model.sv */
// Behavioural model of one port of the dual-port memory device.
// Assumes host pins are registered and change just after core_clk edges.
`timescale 1ns/100ps
module dpc_mem_model (
  input  wire logic        core_clk,
  input  wire logic        holdBusy,
  input  wire logic        selN,
  input  wire logic        wrN,
  input  wire logic        oeN,
  input  wire logic        upperN,
  input  wire logic        lowerN,
  input  wire logic        semN,
  input  wire logic [12:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        dataOeN,
  output logic             collisionN,
  output logic [15:0]      dataIn
);
  logic [15:0] mem [0:8191];      // Array contents
  logic        semBit  = 1'b1;    // Semaphore flag state
  logic        wasBusy = 1'b0;    // Flag was low at the previous edge
  logic [15:0] lastDrv = 16'h0000; // Last value driven on the data pins
  // Access decode from the select pins
  wire semOnly = selN || (upperN && lowerN);
  wire arrWr   = !selN && !wrN && !(upperN && lowerN) && semN;
  wire semWr   = !semN && !wrN && semOnly;
  wire arrRd   = !selN && !oeN && wrN && semN;
  wire semRd   = !semN && !oeN && wrN && semOnly;
  // Pins the host leaves undriven read as garbage
  wire [15:0] wd    = dataOeN ? ~wdata : wdata;
  wire [15:0] rdVal = semRd ? {16{semBit}} : mem[addr];
  ////////////////////////////////////////////////////////////////////////////
  // Push-pull flag, asserted on the bench's command
  // Bench stands in for the far port's arbiter and picks the loser
  assign collisionN = !holdBusy;
  // Released pins show the inverse of the last driven value
  assign dataIn = (arrRd || semRd) ? rdVal : ~lastDrv;
  ////////////////////////////////////////////////////////////////////////////
  // Store during the overlap; a flag low now or one edge ago blocks it
  always @(posedge core_clk) begin
    wasBusy <= holdBusy;
    if (arrRd || semRd) begin
      lastDrv <= rdVal;
    end
    if (!holdBusy && !wasBusy) begin
      if (arrWr && !upperN) begin
        mem[addr][15:8] <= wd[15:8];
      end
      if (arrWr && !lowerN) begin
        mem[addr][7:0] <= wd[7:0];
      end
      if (semWr) begin
        // Single port here, so every request is uncontended
        semBit <= wd[0];
      end
    end
  end
endmodule

/* File: tb.sv */
// Self-checking bench for the host-side port controller.
// Assumes the memory model answers on the same core_clk.
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic        isRd;
    logic [15:0] val;
  } dpc_note_s;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reqValid = 1'b0;
  logic [1:0]  reqOp = 2'b00;
  logic [12:0] reqAddr = 13'h0000;
  logic [15:0] reqData = 16'h0000;
  logic [1:0]  reqLanesN = 2'b11;
  logic        keepOeLow = 1'b0;
  logic        holdBusy = 1'b0;
  logic        collisionN, reqReady_r, rspValid_r, selN_r, wrN_r, oeN_r;
  logic        upperN_r, lowerN_r, semN_r, dataOeN_r;
  logic [15:0] dataIn, rspData_r, dataOut_r, d, d2;
  logic [12:0] addr_r, a, lastAddr;
  logic [1:0]  ln;
  logic        prevWr = 1'b0;
  dpc_note_s   notes[$];
  dpc_note_s   note;
  int          errorCnt = 0;
  int          testsRun = 0;
  int          seed = 88331;
  int          n;
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 100 ns
  always #50 core_clk = ~core_clk;
  dpc_port_ctrl i_dut (.core_clk, .sys_rst, .reqValid, .reqOp, .reqAddr,
    .reqData, .reqLanesN, .keepOeLow, .collisionN, .dataIn, .reqReady_r,
    .rspValid_r, .rspData_r, .selN_r, .wrN_r, .oeN_r, .upperN_r, .lowerN_r,
    .semN_r, .addr_r, .dataOut_r, .dataOeN_r);
  dpc_mem_model i_mem (.core_clk, .holdBusy, .selN(selN_r), .wrN(wrN_r),
    .oeN(oeN_r), .upperN(upperN_r), .lowerN(lowerN_r), .semN(semN_r),
    .addr(addr_r), .wdata(dataOut_r), .dataOeN(dataOeN_r), .collisionN,
    .dataIn);
  ////////////////////////////////////////////////////////////////////////////
  // Report one mismatch
  task automatic noteError(input string m);
    $display("Error %0t: %s", $time, m);
    errorCnt++;
  endtask
  // Print the counts and the verdict, then stop
  task automatic tallyAndFinish;
    $display("Checks %0d, errors %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Issue one request once the controller is idle; note the expectation
  task automatic doReq(input logic [1:0] op, input logic [12:0] ad,
                       input logic [15:0] dt, input logic [1:0] lz,
                       input logic oe, input logic [15:0] ex);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (reqReady_r !== 1'b1 && n < 60);
    notes.push_back('{op[0], ex});
    reqValid  <= 1'b1;
    reqOp     <= op;
    reqAddr   <= ad;
    reqData   <= dt;
    reqLanesN <= lz;
    keepOeLow <= oe;
    @(posedge core_clk);
    reqValid  <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Match each response with the oldest noted expectation
  always @(posedge core_clk) begin
    if (rspValid_r === 1'b1) begin
      testsRun++;
      if (notes.size() == 0) begin
        noteError("response with nothing pending");
      end else begin
        note = notes.pop_front();
        if (note.isRd && rspData_r !== note.val) begin
          noteError($sformatf("read %h, wanted %h", rspData_r, note.val));
        end
      end
    end
  end
  // Pin discipline watched on every edge out of reset
  always @(posedge core_clk) begin
    if (!sys_rst) begin
      if (prevWr && !wrN_r && addr_r !== lastAddr) begin
        noteError("address moved inside a write");
      end
      // Device outputs are on only with output enable low and strobe high
      if (dataOeN_r === 1'b0 && oeN_r === 1'b0 && wrN_r !== 1'b0) begin
        noteError("data driven while device outputs on");
      end
      if (!semN_r && !selN_r && !(upperN_r && lowerN_r)) begin
        noteError("semaphore access with array selected");
      end
    end
    prevWr   <= !wrN_r && !selN_r && !(upperN_r && lowerN_r);
    lastAddr <= addr_r;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    noteError("watchdog expired");
    tallyAndFinish();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    testsRun++;
    if ({selN_r, wrN_r, oeN_r, upperN_r, lowerN_r, semN_r, dataOeN_r}
        !== 7'h7f) begin
      noteError("pins not idle in reset");
    end
    sys_rst <= 1'b0;
    // Full write, partial lane write, read back
    for (int i = 0; i < 8; i++) begin
      a  = 13'($random(seed));
      d  = 16'($random(seed));
      d2 = 16'($random(seed));
      ln = 2'($random(seed));
      doReq(dpc_pkg::OP_ARRAY_WR, a, d, 2'b00, 1'(i), 16'h0000);
      doReq(dpc_pkg::OP_ARRAY_WR, a, d2, ln, 1'(i >> 1), 16'h0000);
      doReq(dpc_pkg::OP_ARRAY_RD, a, 16'h0000, 2'b00, 1'b0,
            {ln[1] ? d[15:8] : d2[15:8], ln[0] ? d[7:0] : d2[7:0]});
    end
    // Semaphore write then read, both flag values
    for (int i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      doReq(dpc_pkg::OP_SEM_WR, 13'h0007, d, 2'b11, 1'b0, 16'h0000);
      doReq(dpc_pkg::OP_SEM_RD, 13'h0007, 16'h0000, 2'b11, 1'b0,
            {16{d[0]}});
    end
    // Write blocked by the collision flag, then released
    d = 16'($random(seed));
    // Raise the flag only once the last read is over, or it stalls there
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (reqReady_r !== 1'b1 && n < 60);
    holdBusy <= 1'b1;
    doReq(dpc_pkg::OP_ARRAY_WR, 13'h0100, d, 2'b00, 1'b1, 16'h0000);
    repeat (5) @(posedge core_clk);
    testsRun++;
    if (wrN_r !== 1'b0 || rspValid_r !== 1'b0) begin
      noteError("write not held while flag low");
    end
    holdBusy <= 1'b0;
    doReq(dpc_pkg::OP_ARRAY_RD, 13'h0100, 16'h0000, 2'b00, 1'b0, d);
    n = 0;
    while (notes.size() != 0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (notes.size() != 0) begin
      noteError("responses missing");
    end
    tallyAndFinish();
  end
endmodule
